/* File: shared/otp_lock_consts.vh */
// constants for the security-region and block-lock command interpreter
// assumes a serial flash front end sampled by a fast system clock
`ifndef OTP_LOCK_CONSTS_VH
`define OTP_LOCK_CONSTS_VH

// opcodes
`define OP_OTP_PROG    8'h42
`define OP_OTP_READ    8'h48
`define OP_LOCK_ONE    8'h36
`define OP_UNLOCK_ONE  8'h39
`define OP_LOCK_READ   8'h3D
`define OP_LOCK_ALL    8'h7E
`define OP_UNLOCK_ALL  8'h98
`define OP_ID_DUAL     8'h92

// phase lengths, in serial clocks, minus one; DMODE_LAST counts the dual address and mode clocks together
`define CMD_LAST       5'h07
`define ADDR_LAST      5'h17
`define DUMMY_LAST     5'h07
`define BYTE_LAST      5'h07
`define DADDR_LAST     5'h0B
`define DMODE_LAST     5'h0F
`define SOUT_LAST      3'h7
`define DOUT_LAST      3'h3

// region address map
`define REGION_HI      8'h00
`define REGION_1       8'h10
`define REGION_2       8'h20
`define REGION_3       8'h30
`define OTP_ERASED     8'hFF

// lock map: 16 sectors at each end, 64 KB blocks between
`define BLK_TOP        7'h7F
`define LOCK_TOP_BASE  8'h10
`define LOCK_MID_BASE  8'h1F
`define LOCK_RESET_VAL 1'b1

`endif

/* File: logic/otp_sync_fifo.v */
// synchronous fifo carrying pending security-region writes
// assumes one clock; both sides use valid/ready
`timescale 1ns/1ps
`default_nettype none
module otp_sync_fifo #(
  parameter WIDTH = 18,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  // clock and reset
  input  wire             clk_sys_i,
  input  wire             rst_n_i,
  // fill side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // drain side
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] buf_mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      level;
  wire            do_push;
  wire            do_pop;

  // full and empty come straight from the fill level
  assign in_ready_o  = (level != DEPTH[AW:0]);
  assign out_valid_o = (level != {(AW+1){1'b0}});
  assign out_data_o  = buf_mem[rd_ptr];
  assign do_push     = in_valid_i & in_ready_o;
  assign do_pop      = out_valid_o & out_ready_i;

  // storage has no reset, only pointers and level do
  always @(posedge clk_sys_i) begin
    if (do_push) begin
      buf_mem[wr_ptr] <= in_data_i;
    end
  end

  // pointer wrap relies on depth being a power of two
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      level  <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_push && !do_pop) begin
        level <= level + 1'b1;
      end else if (do_pop && !do_push) begin
        level <= level - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: logic/otp_lock_cmd.v */
// security-region program/read, block lock commands and dual id read
// assumes serial pins arrive unsynchronised; status bits come from the
// status register logic on clk_sys_i, and the array engine queries protection
`timescale 1ns/1ps
`default_nettype none
`include "otp_lock_consts.vh"
module otp_lock_cmd #(
  parameter NUM_LOCKS   = 158,
  parameter PROG_CYCLES = 4,
  parameter FIFO_DEPTH  = 32,
  parameter FIFO_AW     = 5,
  parameter [7:0] MAKER_ID  = 8'hA5, // arbitrary value
  parameter [7:0] DEVICE_ID = 8'h3C  // arbitrary value
) (
  // clock and reset
  input  wire        clk_sys_i,
  input  wire        rst_n_i,
  // serial pins
  input  wire        cs_n_i,
  input  wire        sclk_i,
  input  wire        io0_i,
  output reg         io0_o,
  output reg         io0_oe_n_o,
  input  wire        io1_i,
  output reg         io1_o,
  output reg         io1_oe_n_o,
  // status bits
  input  wire        write_enable_latch_i,
  input  wire [2:0]  otp_region_lock_bits_i,
  input  wire        protect_scheme_select_i,
  input  wire        range_protect_i,
  input  wire        soft_reset_i,
  output reg         wel_clear_o,
  // protection query from array engine
  input  wire [23:0] prot_query_addr_i,
  output reg         prot_locked_o,
  // write buffer state
  output wire        prog_buf_ready_o,
  output wire        prog_busy_o,
  output reg         prog_drop_o
);
  localparam ST_CMD   = 3'd0;
  localparam ST_ADDR  = 3'd1;
  localparam ST_DUMMY = 3'd2;
  localparam ST_DATA  = 3'd3;
  localparam ST_OUT   = 3'd4;
  localparam ST_DONE  = 3'd5;
  localparam ST_IGN   = 3'd6;
  localparam ST_DADDR = 3'd7;
  localparam LW       = 8;

  // region of an address: 0 when outside the three windows
  function [1:0] region_of;
    input [23:0] a;
    begin
      region_of = 2'd0;
      if (a[23:16] == `REGION_HI) begin
        case (a[15:8])
          `REGION_1: region_of = 2'd1;
          `REGION_2: region_of = 2'd2;
          `REGION_3: region_of = 2'd3;
          default:   region_of = 2'd0;
        endcase
      end
    end
  endfunction

  // lock bit index: 4 KB sectors in first and last block
  function [LW-1:0] lock_index;
    input [23:0] a;
    begin
      if (a[22:16] == 7'h00) begin
        lock_index = {4'h0, a[15:12]};
      end else if (a[22:16] == `BLK_TOP) begin
        lock_index = `LOCK_TOP_BASE + {4'h0, a[15:12]};
      end else begin
        lock_index = `LOCK_MID_BASE + {1'b0, a[22:16]};
      end
    end
  endfunction

  // pin synchronisers
  reg cs_s1, cs_s2, cs_d;
  reg ck_s1, ck_s2, ck_d;
  reg d0_s1, d0_s2, d1_s1, d1_s2;
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      {cs_s1, cs_s2, cs_d} <= 3'h7;
      {ck_s1, ck_s2, ck_d} <= 3'h0;
      {d0_s1, d0_s2, d1_s1, d1_s2} <= 4'h0;
    end else begin
      {cs_s1, cs_s2, cs_d} <= {cs_n_i, cs_s1, cs_s2};
      {ck_s1, ck_s2, ck_d} <= {sclk_i, ck_s1, ck_s2};
      {d0_s1, d0_s2, d1_s1, d1_s2} <= {io0_i, d0_s1, io1_i, d1_s1};
    end
  end
  wire sck_rise = ck_s2 & ~ck_d & ~cs_s2;
  wire sck_fall = ~ck_s2 & ck_d & ~cs_s2;
  wire cs_rise  = cs_s2 & ~cs_d;

  reg  [7:0]  otp_mem [0:767];
  reg  [2:0]  st;
  reg  [4:0]  cnt;
  reg  [2:0]  ocnt;
  reg  [7:0]  op;
  reg  [7:0]  rx;
  reg  [23:0] addr;
  reg  [1:0]  rgn;
  reg  [7:0]  ofs;
  reg  [7:0]  tx;
  reg         dual;
  reg         id_dev;
  reg         prog_ok;
  reg         prog_any;
  reg         push;
  reg  [17:0] push_data;
  reg         lk_one_set, lk_one_clr, lk_all_set, lk_all_clr;
  reg  [LW-1:0] lk_idx;
  reg  [NUM_LOCKS-1:0] block_lock;
  wire [23:0] next_addr = {addr[22:0], d0_s2};
  wire [7:0]  next_rx   = {rx[6:0], d0_s2};
  wire [1:0]  next_rgn  = region_of(next_addr);
  wire [7:0]  mem_rd    = (rgn == 2'd0) ? `OTP_ERASED : otp_mem[{rgn - 2'd1, ofs}];
  wire [7:0]  lock_byte = {7'h00, block_lock[lock_index(addr)]};
  wire        fifo_in_ready;
  wire        fifo_valid;
  wire [17:0] fifo_data;
  reg  [7:0]  prog_wait;

  // erased at power-up; nothing here erases afterwards
  integer k;
  initial begin
    for (k = 0; k < 768; k = k + 1) begin
      otp_mem[k] = `OTP_ERASED;
    end
  end

  // command sequencer; all serial edges seen through the synchronisers
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      st <= ST_CMD;
      cnt <= 5'h00;
      ocnt <= 3'h0;
      op <= 8'h00;
      rx <= 8'h00;
      addr <= 24'h000000;
      rgn <= 2'd0;
      ofs <= 8'h00;
      tx <= 8'h00;
      dual <= 1'b0;
      id_dev <= 1'b0;
      prog_ok <= 1'b0;
      prog_any <= 1'b0;
      push <= 1'b0;
      push_data <= 18'h00000;
      prog_drop_o <= 1'b0;
      wel_clear_o <= 1'b0;
      {lk_one_set, lk_one_clr, lk_all_set, lk_all_clr} <= 4'h0;
      lk_idx <= {LW{1'b0}};
      io0_o <= 1'b0;
      io1_o <= 1'b0;
      io0_oe_n_o <= 1'b1;
      io1_oe_n_o <= 1'b1;
    end else begin
      push <= 1'b0;
      prog_drop_o <= 1'b0;
      wel_clear_o <= 1'b0;
      {lk_one_set, lk_one_clr, lk_all_set, lk_all_clr} <= 4'h0;
      if (cs_s2) begin
        // select high ends every command and floats the outputs
        st <= ST_CMD;
        cnt <= 5'h00;
        ocnt <= 3'h0;
        dual <= 1'b0;
        io0_oe_n_o <= 1'b1;
        io1_oe_n_o <= 1'b1;
        prog_ok <= 1'b0;
        prog_any <= 1'b0;
        if (cs_rise) begin
          if (prog_any) begin
            wel_clear_o <= 1'b1;
          end
          // lock commands only act on a clean select release
          if (st == ST_DONE && write_enable_latch_i) begin
            lk_idx <= lock_index(addr);
            lk_one_set <= (op == `OP_LOCK_ONE);
            lk_one_clr <= (op == `OP_UNLOCK_ONE);
            lk_all_set <= (op == `OP_LOCK_ALL);
            lk_all_clr <= (op == `OP_UNLOCK_ALL);
            wel_clear_o <= 1'b1;
          end
        end
      end else if (sck_rise) begin
        // inputs captured on rising serial clock
        cnt <= cnt + 5'h01;
        case (st)
          ST_CMD: begin
            rx <= next_rx;
            if (cnt == `CMD_LAST) begin
              op <= next_rx;
              cnt <= 5'h00;
              case (next_rx)
                `OP_OTP_PROG, `OP_OTP_READ, `OP_LOCK_ONE,
                `OP_UNLOCK_ONE, `OP_LOCK_READ: st <= ST_ADDR;
                `OP_LOCK_ALL, `OP_UNLOCK_ALL:  st <= ST_DONE;
                `OP_ID_DUAL:                   st <= ST_DADDR;
                default:                       st <= ST_IGN;
              endcase
            end
          end
          ST_ADDR: begin
            addr <= next_addr;
            if (cnt == `ADDR_LAST) begin
              cnt <= 5'h00;
              rgn <= next_rgn;
              ofs <= next_addr[7:0];
              case (op)
                `OP_OTP_PROG: begin
                  st <= ST_DATA;
                  // latch closed or locked region makes the data inert
                  prog_ok <= write_enable_latch_i & (next_rgn != 2'd0) &
                             ~otp_region_lock_bits_i[next_rgn - 2'd1];
                end
                `OP_OTP_READ: st <= ST_DUMMY;
                `OP_LOCK_READ: begin
                  st <= ST_OUT;
                  tx <= {7'h00, block_lock[lock_index(next_addr)]};
                end
                default: st <= ST_DONE;
              endcase
            end
          end
          ST_DUMMY: begin
            if (cnt == `DUMMY_LAST) begin
              st <= ST_OUT;
              tx <= mem_rd;
              ofs <= ofs + 8'h01;
            end
          end
          ST_DATA: begin
            rx <= next_rx;
            if (cnt == `BYTE_LAST) begin
              cnt <= 5'h00;
              ofs <= ofs + 8'h01;
              if (prog_ok) begin
                // data byte with its own address travels to the writer
                push <= fifo_in_ready;
                prog_drop_o <= ~fifo_in_ready;
                push_data <= {rgn, ofs, next_rx};
                prog_any <= 1'b1;
              end
            end
          end
          ST_DADDR: begin
            // address two bits a clock, then mode bits ignored
            if (cnt <= `DADDR_LAST) begin
              addr <= {addr[21:0], d1_s2, d0_s2};
            end
            if (cnt == `DMODE_LAST) begin
              st <= ST_OUT;
              dual <= 1'b1;
              id_dev <= addr[0];
              tx <= addr[0] ? DEVICE_ID : MAKER_ID;
            end
          end
          ST_DONE: st <= ST_IGN; // extra clocks void the command
          default: st <= st;
        endcase
      end else if (sck_fall && st == ST_OUT) begin
        // outputs change on falling serial clock
        io1_oe_n_o <= 1'b0;
        io1_o <= tx[7];
        ocnt <= ocnt + 3'h1;
        if (dual) begin
          io0_oe_n_o <= 1'b0;
          io0_o <= tx[6];
          tx <= {tx[5:0], 2'b00};
        end else begin
          tx <= {tx[6:0], 1'b0};
        end
        if ((dual && ocnt == `DOUT_LAST) || (!dual && ocnt == `SOUT_LAST)) begin
          ocnt <= 3'h0;
          case (op)
            `OP_OTP_READ: begin
              tx <= mem_rd;
              ofs <= ofs + 8'h01; // wraps inside the region
            end
            `OP_ID_DUAL: begin
              id_dev <= ~id_dev;
              tx <= id_dev ? MAKER_ID : DEVICE_ID;
            end
            default: tx <= lock_byte; // repeats the lock value
          endcase
        end
      end
    end
  end

  // volatile lock bits, one per block or sector
  genvar g;
  generate
    for (g = 0; g < NUM_LOCKS; g = g + 1) begin : g_lock
      always @(posedge clk_sys_i) begin
        if (!rst_n_i || soft_reset_i || lk_all_set) begin
          block_lock[g] <= `LOCK_RESET_VAL;
        end else if (lk_all_clr) begin
          block_lock[g] <= 1'b0;
        end else if (lk_idx == g) begin
          if (lk_one_set) begin
            block_lock[g] <= 1'b1;
          end else if (lk_one_clr) begin
            block_lock[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // protection answer: lock bits only count under the per-block scheme
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      prot_locked_o <= 1'b1;
    end else begin
      prot_locked_o <= protect_scheme_select_i ?
                       block_lock[lock_index(prot_query_addr_i)] :
                       range_protect_i;
    end
  end

  // write buffer decouples the serial stream from the slow cell write
  otp_sync_fifo #(
    .WIDTH (18),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (push_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (prog_wait == 8'h00),
    .out_data_o  (fifo_data)
  );
  assign prog_buf_ready_o = fifo_in_ready;
  assign prog_busy_o      = fifo_valid | (prog_wait != 8'h00);

  // cell writer: AND keeps erased-only semantics, a byte costs PROG_CYCLES plus one clocks
  always @(posedge clk_sys_i) begin
    if (fifo_valid && prog_wait == 8'h00) begin
      otp_mem[{fifo_data[17:16] - 2'd1, fifo_data[15:8]}] <=
        otp_mem[{fifo_data[17:16] - 2'd1, fifo_data[15:8]}] & fifo_data[7:0];
    end
  end
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      prog_wait <= 8'h00;
    end else if (fifo_valid && prog_wait == 8'h00) begin
      prog_wait <= PROG_CYCLES[7:0];
    end else if (prog_wait != 8'h00) begin
      prog_wait <= prog_wait - 8'h01;
    end
  end
endmodule
`default_nettype wire

/* File: test/spi_host_model.sv */
// serial host model: mode 0 master on select, clock and two data lines
// assumes the bench resolves the shared data wires and feeds them back
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  // serial pins
  output logic       cs_n_o,
  output logic       sclk_o,
  output logic       io0_o,
  output logic       io1_o,
  input  wire logic  io0_i,
  input  wire logic  io1_i,
  // received bytes
  output logic       rx_stb_o,
  output logic [7:0] rx_byte_o
);
  // idle pins; clock stands low outside frames
  initial begin
    cs_n_o = 1'h1;
    sclk_o = 1'h0;
    io0_o = 1'h0;
    io1_o = 1'h0;
    rx_stb_o = 1'h0;
    rx_byte_o = 8'h00;
  end
  // one clock: drive while low, sample at the rise
  task automatic bit2(input logic [1:0] d, output logic [1:0] q);
    io1_o = d[1];
    io0_o = d[0];
    #40 sclk_o = 1'h1;
    q = {io1_i, io0_i};
    #40 sclk_o = 1'h0;
  endtask
  // single-line bits; io1 is released, so it toggles every clock
  task automatic tx(input logic [31:0] v, input int n);
    logic [1:0] q;
    for (int i = n - 1; i >= 0; i--) bit2({~io1_o, v[i]}, q);
  endtask
  // two bits per clock, io1 carries the higher bit
  task automatic dtx(input logic [31:0] v, input int n);
    logic [1:0] q;
    for (int i = n - 1; i >= 0; i--) bit2(v[2*i+:2], q);
  endtask
  // one byte in, msb first; released lines toggle so stale values never match
  task automatic rx(input logic dual);
    logic [1:0] q;
    logic [7:0] b;
    b = 8'h00;
    for (int i = 0; i < (dual ? 4 : 8); i++) begin
      bit2(~{io1_o, io0_o}, q);
      b = dual ? {b[5:0], q} : {b[6:0], q[1]};
    end
    rx_byte_o = b;
    rx_stb_o = 1'h1;
    #1 rx_stb_o = 1'h0;
  endtask
  // odd offset keeps the link clock unrelated to the system clock
  task automatic open_f(input logic [7:0] op);
    #1 cs_n_o = 1'h0;
    #36 tx({24'h0, op}, 8);
  endtask
  // select stays low from open_f up to here, whole bytes only
  task automatic close_f;
    #40 cs_n_o = 1'h1;
    #120;
  endtask
endmodule
`default_nettype wire

/* File: test/otp_lock_cmd_sva.sv */
// port-level checks on the security-region and block-lock interpreter
// assumes one clock domain and a write enable level held by the bench
`timescale 1ns/1ps
`default_nettype none
module otp_lock_cmd_sva (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // pins and status
  input wire logic cs_n_i,
  input wire logic io0_oe_n_o,
  input wire logic io1_oe_n_o,
  input wire logic write_enable_latch_i,
  input wire logic protect_scheme_select_i,
  input wire logic range_protect_i,
  input wire logic soft_reset_i,
  input wire logic wel_clear_o,
  input wire logic prot_locked_o,
  input wire logic prog_buf_ready_o,
  input wire logic prog_busy_o,
  input wire logic prog_drop_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // select idle long enough for the synchronisers to see it
  sequence s_cs_idle;
    cs_n_i [*5];
  endsequence
  // select was already high two samples back
  sequence s_cs_was_high;
    $past(cs_n_i, 2);
  endsequence
  // locks forced by soft reset, scheme select kept
  sequence s_soft_locked;
    soft_reset_i ##1 protect_scheme_select_i [*3];
  endsequence
  a_pins_released: assert property (s_cs_idle |-> io0_oe_n_o && io1_oe_n_o)
    else $error("data pins still driven with select idle");
  a_dual_both: assert property (!io0_oe_n_o |-> !io1_oe_n_o)
    else $error("io0 driven without io1");
  a_wel_pulse: assert property (wel_clear_o |=> !wel_clear_o)
    else $error("completion pulse longer than one cycle");
  a_wel_gate: assert property (wel_clear_o |-> $past(write_enable_latch_i))
    else $error("command accepted with write enable low");
  a_cmd_end: assert property (wel_clear_o |-> s_cs_was_high)
    else $error("command completed before select rose");
  a_full_busy: assert property (!prog_buf_ready_o |-> prog_busy_o)
    else $error("buffer full but not busy");
  a_drop_full: assert property (prog_drop_o |-> !$past(prog_buf_ready_o) ||
                                !$past(prog_buf_ready_o, 2))
    else $error("byte dropped while buffer had room");
  a_prot_range: assert property (!protect_scheme_select_i |=>
                                 prot_locked_o == $past(range_protect_i))
    else $error("protection ignores range result");
  a_prot_reset: assert property ($rose(rst_n_i) |-> prot_locked_o)
    else $error("array unprotected after reset");
  a_soft_lock: assert property (s_soft_locked |-> prot_locked_o)
    else $error("soft reset left a block unlocked");
endmodule
bind otp_lock_cmd otp_lock_cmd_sva u_sva (
  .clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i),
  .cs_n_i(cs_n_i),
  .io0_oe_n_o(io0_oe_n_o),
  .io1_oe_n_o(io1_oe_n_o),
  .write_enable_latch_i(write_enable_latch_i),
  .protect_scheme_select_i(protect_scheme_select_i),
  .range_protect_i(range_protect_i),
  .soft_reset_i(soft_reset_i),
  .wel_clear_o(wel_clear_o),
  .prot_locked_o(prot_locked_o),
  .prog_buf_ready_o(prog_buf_ready_o),
  .prog_busy_o(prog_busy_o),
  .prog_drop_o(prog_drop_o)
);
`default_nettype wire

/* File: test/testbench.sv */
// self-checking bench for the security-region and block-lock interpreter
// assumes the host model's tasks run one frame at a time from here
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [7:0]  MAKER = 8'h5A; // arbitrary value
  localparam logic [7:0]  DEVID = 8'hC3; // arbitrary value
  localparam logic [23:0] BLK_A = 24'h050000;
  localparam logic [23:0] BLK_B = 24'h060000;
  logic        clk_sys_i;
  logic        rst_n_i;
  logic        cs_n;
  logic        sclk;
  logic        h_io0;
  logic        h_io1;
  logic        io0_o;
  logic        io0_oe_n;
  logic        io1_o;
  logic        io1_oe_n;
  logic        write_enable_latch;
  logic [2:0]  lockbits;
  logic        protect_scheme_select;
  logic        range_p;
  logic        soft_rst;
  logic [23:0] qaddr;
  logic        prot_locked;
  logic        buf_ready;
  logic        drop;
  logic        wel_clr;
  logic        saw_clear;
  logic        busy;
  logic        rx_stb;
  logic [7:0]  rx_byte;
  logic        q_stb;
  logic        saw_full;
  logic        saw_drop;
  logic [7:0]  mem [4][256];
  logic [7:0]  exp_q [$];
  int          err_count;
  int          checked;
  // the device wins a shared line whenever it enables its driver
  wire logic   io0_w = io0_oe_n ? h_io0 : io0_o;
  wire logic   io1_w = io1_oe_n ? h_io1 : io1_o;
  spi_host_model h (.cs_n_o(cs_n), .sclk_o(sclk), .io0_o(h_io0), .io1_o(h_io1),
    .io0_i(io0_w), .io1_i(io1_w), .rx_stb_o(rx_stb), .rx_byte_o(rx_byte));
  // slow cell writes so the serial link can outrun the write buffer
  otp_lock_cmd #(.PROG_CYCLES(255), .MAKER_ID(MAKER), .DEVICE_ID(DEVID)) dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .sclk_i(sclk),
    .io0_i(io0_w), .io0_o(io0_o), .io0_oe_n_o(io0_oe_n), .io1_i(io1_w),
    .io1_o(io1_o), .io1_oe_n_o(io1_oe_n), .write_enable_latch_i(write_enable_latch),
    .otp_region_lock_bits_i(lockbits), .protect_scheme_select_i(protect_scheme_select),
    .range_protect_i(range_p), .soft_reset_i(soft_rst), .wel_clear_o(wel_clr),
    .prot_query_addr_i(qaddr), .prot_locked_o(prot_locked),
    .prog_buf_ready_o(buf_ready), .prog_busy_o(busy), .prog_drop_o(drop));
  initial begin
    clk_sys_i = 1'h0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  // remember that the buffer refused and lost bytes at least once
  always @(posedge clk_sys_i) begin
    if (buf_ready === 1'h0) saw_full <= 1'h1;
    if (drop === 1'h1) saw_drop <= 1'h1;
    if (wel_clr === 1'h1) saw_clear <= 1'h1;
  end
  // compare each result with the oldest note
  always @(posedge rx_stb or posedge q_stb) begin
    logic [7:0] got;
    got = rx_stb ? rx_byte : {7'h00, prot_locked};
    checked++;
    if (exp_q.size() == 0 || got !== exp_q[0]) begin
      err_count++;
      $display("ERROR %0t unexpected result %h", $time, got);
    end
    if (exp_q.size() != 0) void'(exp_q.pop_front());
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic query(input logic [23:0] a, input logic e);
    exp_q.push_back({7'h00, e});
    @(posedge clk_sys_i) qaddr <= a;
    repeat (3) @(posedge clk_sys_i);
    #1 q_stb = 1'h1;
    #1 q_stb = 1'h0;
  endtask
  task automatic lk(input logic [7:0] op, input logic [23:0] a, input int na);
    h.open_f(op);
    h.tx({8'h00, a}, na);
    h.close_f();
  endtask
  task automatic rdlock(input logic [23:0] a, input logic e);
    h.open_f(8'h3D);
    h.tx({8'h00, a}, 24);
    repeat (2) begin
      exp_q.push_back({7'h00, e});
      h.rx(1'h0);
    end
    h.close_f();
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 20000 && busy !== 1'h0; i++) @(posedge clk_sys_i);
    checked++;
    if (busy !== 1'h0) begin
      err_count++;
      $display("ERROR %0t write buffer never drained", $time);
    end
  endtask
  // only the first keep bytes are modelled; later ones may be dropped
  task automatic prog(input logic [7:0] r, input logic [7:0] off, input int n, input int keep);
    logic [7:0] d;
    logic       ok;
    ok = write_enable_latch && !lockbits[r[5:4] - 2'h1];
    h.open_f(8'h42);
    h.tx({8'h00, r, off}, 24);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      if (ok && i < keep) mem[r[5:4]][8'(off + i)] &= d;
      h.tx({24'h0, d}, 8);
    end
    h.close_f();
    wait_idle();
  endtask
  task automatic rd(input logic [7:0] r, input logic [7:0] off, input int n);
    h.open_f(8'h48);
    h.tx({8'h00, r, off}, 24);
    h.tx(32'h0, 8);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(mem[r[5:4]][8'(off + i)]);
      h.rx(1'h0);
    end
    h.close_f();
  endtask
  task automatic did(input logic a0);
    h.open_f(8'h92);
    h.dtx({31'h0, a0}, 12);
    h.dtx(32'hF0, 4);
    for (int i = 0; i < 3; i++) begin
      exp_q.push_back((i[0] ^ a0) ? DEVID : MAKER);
      h.rx(1'h1);
    end
    h.close_f();
  endtask
  task automatic setp(input logic s, input logic r);
    @(posedge clk_sys_i) protect_scheme_select <= s;
    range_p <= r;
  endtask
  initial begin
    #600000;
    err_count++;
    $display("ERROR %0t run did not finish", $time);
    wrap_up();
  end
  initial begin
    void'($urandom(32'hCF4B9406));
    rst_n_i = 1'h0;
    write_enable_latch = 1'h0;
    lockbits = 3'h0;
    // either scheme must report the fully locked reset state
    protect_scheme_select = 1'($urandom);
    range_p = 1'h1;
    saw_clear = 1'h0;
    soft_rst = 1'h0;
    qaddr = 24'h0;
    q_stb = 1'h0;
    saw_full = 1'h0;
    saw_drop = 1'h0;
    err_count = 0;
    checked = 0;
    foreach (mem[i, j]) mem[i][j] = 8'hFF;
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'h1;
    repeat (5) @(posedge clk_sys_i);
    query(24'($urandom), 1'h1);
    rdlock(BLK_A, 1'h1);
    $display("test reset_state done");
    lk(8'h98, 24'h0, 0);
    query(BLK_B, 1'h1);
    prog(8'h10, 8'h00, 2, 2);
    rd(8'h10, 8'h00, 2);
    checked++;
    if (saw_clear !== 1'h0) begin
      err_count++;
      $display("ERROR %0t command completed with write enable low", $time);
    end
    $display("test write_disabled done");
    @(posedge clk_sys_i) write_enable_latch <= 1'h1;
    setp(1'h1, 1'($urandom));
    lk(8'h98, 24'h0, 0);
    query(24'($urandom), 1'h0);
    lk(8'h36, BLK_A, 24);
    rdlock(BLK_A, 1'h1);
    query(BLK_B, 1'h0);
    lk(8'h39, BLK_A, 24);
    rdlock(BLK_A, 1'h0);
    setp(1'h0, 1'h1);
    query(BLK_A, 1'h1);
    setp(1'h1, 1'($urandom));
    lk(8'h7E, 24'h0, 0);
    query(24'($urandom), 1'h1);
    query(BLK_B, 1'h1);
    setp(1'h0, 1'h0);
    query(BLK_B, 1'h0);
    setp(1'h1, 1'($urandom));
    lk(8'h98, 24'h0, 0);
    @(posedge clk_sys_i) soft_rst <= 1'h1;
    @(posedge clk_sys_i) soft_rst <= 1'h0;
    query(BLK_A, 1'h1);
    $display("test block_locks done");
    // region 3 locked, region 2 kept open for the buffer test
    @(posedge clk_sys_i) lockbits <= {1'h1, 1'h0, 1'($urandom)};
    for (int r = 1; r < 4; r++) prog(8'(r * 16), 8'hFE, 3, 3);
    for (int r = 1; r < 4; r++) rd(8'(r * 16), 8'hFE, 4);
    prog(8'h10, 8'hFF, 2, 2);
    rd(8'h10, 8'hFF, 2);
    rd(8'h40, 8'h00, 1);
    $display("test regions done");
    did(1'h0);
    did(1'h1);
    $display("test dual_id done");
    prog(8'h20, 8'h10, 64, 4);
    rd(8'h20, 8'h10, 4);
    checked++;
    if (saw_full !== 1'h1 || saw_drop !== 1'h1 || saw_clear !== 1'h1) begin
      err_count++;
      $display("ERROR %0t buffer refusal or command completion never seen", $time);
    end
    $display("test buffer_fill done");
    wrap_up();
  end
endmodule
`default_nettype wire
